// file: inc/thp_bus_if.sv
// Pins between host and device; resolves shared and pulled-up lines.
// Assumes both ends run on one clock supplied outside the interface.
`timescale 1ns/1ps
`include "thp_regs.svh"

interface thp_bus_if;
  logic                     cs_n;              // Chip select, active low
  logic                     data_strobe_n;     // Data strobe, active low
  logic                     rd_wr;             // 1 read, 0 write
  logic [`THP_LANES-1:0]    byte_lane_select;  // Byte strobes or enables, low
  logic [`THP_ADDR_W-1:0]   host_address_bus;  // Address, bit 0 unused
  logic                     bus_style_select;  // 0 strobes, 1 enables
  logic                     device_reset_n;    // Device reset, active low
  logic [`THP_DATA_W-1:0]   host_dout;         // Host drive of data bus
  logic                     host_doe;          // Host drives data bus
  logic [`THP_DATA_W-1:0]   dev_dout;          // Device drive of data bus
  logic                     dev_doe;           // Device drives data bus
  logic                     ack_o;             // Acknowledge drive level
  logic                     ack_oe;            // Acknowledge driven
  logic                     bus_error_n_o;            // Bus error drive level
  logic                     bus_error_n_oe;           // Bus error driven
  logic                     wait_o;            // Wait drive level
  logic                     wait_oe;           // Wait driven
  logic [`THP_DATA_W-1:0]   host_data_bus;     // Resolved data bus
  logic                     transfer_ack_n;    // Resolved acknowledge
  logic                     bus_error_n;       // Resolved bus error
  logic                     wait_n;            // Resolved wait

  // Released lines float to the external pull-up level
  assign transfer_ack_n = ack_oe ? ack_o : 1'h1;
  assign bus_error_n    = bus_error_n_oe ? bus_error_n_o : 1'h1;
  assign wait_n         = wait_oe ? wait_o : 1'h1;
  // Undriven data bus shows the inverse of the last host value, never a held read
  assign host_data_bus  = dev_doe ? dev_dout : (host_doe ? host_dout : ~host_dout);

  modport dev (
    input  cs_n, data_strobe_n, rd_wr, byte_lane_select, host_address_bus,
    input  bus_style_select, device_reset_n, host_dout, host_doe,
    output dev_dout, dev_doe, ack_o, ack_oe, bus_error_n_o, bus_error_n_oe, wait_o, wait_oe
  );

  modport host (
    output cs_n, data_strobe_n, rd_wr, byte_lane_select, host_address_bus,
    output bus_style_select, device_reset_n, host_dout, host_doe,
    input  host_data_bus, transfer_ack_n, bus_error_n, wait_n
  );
endinterface

// file: inc/thp_pkg.sv
// Types shared by both ends of the host bus port.
// Assumes thp_regs.svh is on the include path.
`include "thp_regs.svh"

package thp_pkg;

  // Device end access sequence
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_STRETCH,
    DEV_ANSWER
  } thp_dev_state_t;

  // Host end access sequence
  typedef enum logic [1:0] {
    HST_IDLE,
    HST_SETUP,
    HST_STROBE,
    HST_RELEASE
  } thp_hst_state_t;

endpackage

// file: inc/thp_regs.svh
// Constants of the host bus port: widths, encodings and timing counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef THP_REGS_SVH
`define THP_REGS_SVH

`define THP_ADDR_W        19          // Address bus width, bit 0 unused
`define THP_DATA_W        16          // Data bus width
`define THP_LANES         2           // Byte lanes on the data bus
`define THP_MEM_WORDS     1024        // Valid words behind the port
`define THP_WAIT_CYCLES   2           // Cycles the device stretches an access
`define THP_HOST_TIMEOUT  64          // Host gives up after this many cycles
`define THP_RW_WRITE      1'h0        // Read-not-write level for a write
`define THP_RW_READ       1'h1        // Read-not-write level for a read
`define THP_STYLE_STROBE  1'h0        // Bus style 0: byte strobes
`define THP_STYLE_ENABLE  1'h1        // Bus style 1: byte enables
`define THP_LANE_LOW      0           // Lane select bit for the low byte
`define THP_LANE_HIGH     1           // Lane select bit for the high byte

`endif

// file: verification/thp_chk.sv
// Checker of the host bus port wire, fed with the joined interface lines.
// Assumes one clock and a sync high reset shared by both ends.
`timescale 1ns/1ps
`include "thp_regs.svh"

module thp_chk #(
  parameter int MEM_WORDS = `THP_MEM_WORDS
) (
  input wire logic                   clk_sys,
  input wire logic                   srst,
  input wire logic                   cs_n,
  input wire logic                   data_strobe_n,
  input wire logic                   rd_wr,
  input wire logic [`THP_ADDR_W-1:0] host_address_bus,
  input wire logic                   bus_style_select,
  input wire logic                   device_reset_n,
  input wire logic                   dev_doe,
  input wire logic                   ack_o,
  input wire logic                   ack_oe,
  input wire logic                   bus_error_n_o,
  input wire logic                   bus_error_n_oe,
  input wire logic                   wait_o,
  input wire logic                   wait_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic bad;  // Address outside the valid words
  logic any;  // Any answer line driven
  assign bad = host_address_bus[`THP_ADDR_W-1:1] >= MEM_WORDS;
  assign any = ack_oe | bus_error_n_oe | wait_oe | dev_doe;

  chk_take_strobe: assert property ($rose(wait_oe) |-> $past(!cs_n && !data_strobe_n))
    else $error("stretch began without select and strobe");
  chk_wait_two: assert property ($rose(wait_oe) |-> wait_oe ##1 wait_oe ##1 !wait_oe)
    else $error("stretch length wrong");
  chk_drive_low: assert property (!(ack_oe && wait_oe) && !((ack_oe && ack_o) || (bus_error_n_oe && bus_error_n_o) || (wait_oe && wait_o)))
    else $error("answer line driven high");
  chk_bus_error_n_addr: assert property ($fell(wait_oe) && !data_strobe_n |-> bus_error_n_oe == bad)
    else $error("bus error does not match address");
  chk_bus_error_n_no_ack: assert property (bus_error_n_oe && bus_style_select == `THP_STYLE_STROBE |-> !ack_oe)
    else $error("acknowledge with bus error in style 0");
  chk_ack_answer: assert property ($fell(wait_oe) && !data_strobe_n |-> ack_oe == (bus_style_select || !bad))
    else $error("acknowledge missing or extra");
  chk_read_drive: assert property (dev_doe |-> rd_wr == `THP_RW_READ && $past(!cs_n))
    else $error("data bus driven outside a read");
  chk_reset_quiet: assert property (!device_reset_n |-> !any)
    else $error("answer line driven in reset");
  chk_release_all: assert property ($rose(data_strobe_n) |-> ##[1:2] !any)
    else $error("answer lines not released");

  cover property ($rose(ack_oe) && rd_wr);
  cover property (bus_error_n_oe && !bus_style_select);
  cover property (bus_error_n_oe && ack_oe);
endmodule // thp_chk

// file: verification/thp_tb_top.sv
// Testbench of the host bus port: host end drives device end over the bus.
// Assumes design, package and interface files are compiled first.
`timescale 1ns/1ps
`include "thp_regs.svh"

module thp_tb_top;
  logic                   clk_sys, srst, req, req_read, style_in, reset_in;  // Bench drives
  logic [`THP_ADDR_W-1:0] req_addr;
  logic [`THP_DATA_W-1:0] req_wdata, rdata;
  logic [`THP_LANES-1:0]  req_lanes_n;
  logic                   busy, done, bus_err, timed_out, access_busy, access_error;  // Observed
  logic [`THP_ADDR_W-2:0] last_word_addr;
  int                     fails, comparisons, ack_cnt, wait_cnt, a0, w0;

  thp_bus_if thp_bus_if_inst ();
  thp_dev_port thp_dev_port_inst (.clk_sys(clk_sys), .srst(srst), .bus(thp_bus_if_inst),
    .access_busy(access_busy), .access_error(access_error), .last_word_addr(last_word_addr));
  thp_host_port #(.TIMEOUT(8)) thp_host_port_inst (.clk_sys(clk_sys), .srst(srst), .bus(thp_bus_if_inst),
    .req(req), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes_n(req_lanes_n),
    .style_in(style_in), .reset_in(reset_in), .busy(busy), .done(done), .rdata(rdata), .bus_err(bus_err),
    .timed_out(timed_out));
  thp_chk thp_chk_inst (.clk_sys(clk_sys), .srst(srst), .cs_n(thp_bus_if_inst.cs_n),
    .data_strobe_n(thp_bus_if_inst.data_strobe_n), .rd_wr(thp_bus_if_inst.rd_wr),
    .host_address_bus(thp_bus_if_inst.host_address_bus), .bus_style_select(thp_bus_if_inst.bus_style_select),
    .device_reset_n(thp_bus_if_inst.device_reset_n), .dev_doe(thp_bus_if_inst.dev_doe),
    .ack_o(thp_bus_if_inst.ack_o), .ack_oe(thp_bus_if_inst.ack_oe), .bus_error_n_o(thp_bus_if_inst.bus_error_n_o),
    .bus_error_n_oe(thp_bus_if_inst.bus_error_n_oe), .wait_o(thp_bus_if_inst.wait_o), .wait_oe(thp_bus_if_inst.wait_oe));

  // Clock of 40 ns
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Count cycles of acknowledge and wait on the wire
  always @(posedge clk_sys) begin
    if (thp_bus_if_inst.transfer_ack_n === 1'h0) ack_cnt++;
    if (thp_bus_if_inst.wait_n === 1'h0) wait_cnt++;
  end

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One host access, waits for done under a bound
  task automatic access(input logic st, input logic rd, input logic [18:0] a, input logic [15:0] d,
                        input logic [1:0] ln);
    int n;
    a0 = ack_cnt;
    w0 = wait_cnt;
    n = 0;
    @(posedge clk_sys);
    req <= 1'h1;
    req_read <= rd;
    req_addr <= a;
    req_wdata <= d;
    req_lanes_n <= ln;
    style_in <= st;
    @(posedge clk_sys);
    req <= 1'h0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'h1 && n < 40);
    check(done, 1);
    check({thp_bus_if_inst.transfer_ack_n, thp_bus_if_inst.wait_n, thp_bus_if_inst.bus_error_n}, 7);
    check(busy, 0);
    check(access_busy, 0);
  endtask

  // Write and read back the last valid word
  task automatic t_basic();
    access(1'h0, 1'h0, 19'h007fe, 16'ha55a, 2'h0);
    check(wait_cnt - w0, 2);
    access(1'h0, 1'h1, 19'h007fe, 16'h0000, 2'h0);
    check(rdata, 16'ha55a);
    check(bus_err, 0);
    check(access_error, 0);
    check(last_word_addr, 18'h003ff);
  endtask

  // Byte lanes in both styles
  task automatic t_lanes();
    for (int s = 0; s < 2; s++) begin
      access(s[0], 1'h0, 19'h00010, 16'h1234, 2'h0);
      access(s[0], 1'h0, 19'h00010, 16'habcd, 2'h2);
      access(s[0], 1'h1, 19'h00010, 16'h0000, 2'h0);
      check(rdata, 16'h12cd);
      access(s[0], 1'h1, 19'h00010, 16'h0000, 2'h1);
      check(rdata, 16'h1200);
    end
  endtask

  // First invalid word in both styles
  task automatic t_bus_error_n();
    for (int s = 0; s < 2; s++) begin
      access(s[0], 1'h0, 19'h00800, 16'hffff, 2'h0);
      check(bus_err, 1);
      check(access_error, 1);
      check(ack_cnt != a0, s);
      check(timed_out, 0);
      access(s[0], 1'h1, 19'h00800, 16'h0000, 2'h0);
      check(rdata, 0);
    end
  endtask

  // Access refused while device held in reset
  task automatic t_reset();
    @(posedge clk_sys);
    reset_in <= 1'h1;
    repeat (3) @(posedge clk_sys);
    access(1'h0, 1'h1, 19'h00010, 16'h0000, 2'h0);
    check(timed_out, 1);
    check(wait_cnt - w0, 0);
    @(posedge clk_sys);
    reset_in <= 1'h0;
    repeat (6) @(posedge clk_sys);
    access(1'h0, 1'h1, 19'h00010, 16'h0000, 2'h0);
    check(timed_out, 0);
  endtask

  // Main sequence
  initial begin
    {srst, req, req_read, style_in, reset_in} = 5'h10;
    req_addr = '0;
    req_wdata = '0;
    req_lanes_n = '0;
    {fails, comparisons, ack_cnt, wait_cnt} = '0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'h0;
    repeat (5) @(posedge clk_sys);
    t_basic();
    t_lanes();
    t_bus_error_n();
    t_reset();
    summarize();
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule // thp_tb_top

// file: verilog/thp_dev_port.sv
// Device end of the host bus port: decode, wait stretch, answer, memory.
// Assumes host pins are synchronous to clk_sys and joined by thp_bus_if.
//
// Contract
// - Access only with chip select and strobe low
// - Read-not-write: 0 write, 1 read
// - Acknowledge low on completion, else released
// - Bus error low for invalid address, else released
// - Style 0: bus error suppresses acknowledge
// - Style 1: acknowledge regardless of bus error
// - Wait driven low to stretch, else released
// - Style 0: lane inputs are byte strobes
// - Style 1: lane inputs are byte enables
// - Style select pin picks bus style
// - Device reset asynchronous, active low
// - 19-bit address, bit 0 ignored
// - Data bus driven only on reads
`timescale 1ns/1ps
`include "thp_regs.svh"

module thp_dev_port #(
  parameter int MEM_WORDS   = `THP_MEM_WORDS,
  parameter int WAIT_CYCLES = `THP_WAIT_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  thp_bus_if.dev                      bus,
  output logic                        access_busy,
  output logic                        access_error,
  output logic [`THP_ADDR_W-2:0]      last_word_addr
);
  localparam int IW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;  // Memory index width
  localparam int WW = `THP_ADDR_W - 1;                           // Word address width
  localparam int CW = (WAIT_CYCLES > 1) ? $clog2(WAIT_CYCLES) : 1;

  // Lane mask from active-low lane inputs; same lane order in both styles
  function automatic logic [`THP_DATA_W-1:0] lane_mask(input logic [`THP_LANES-1:0] sel_n);
    logic [`THP_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < `THP_LANES; i++) begin
      m[i*8 +: 8] = {8{~sel_n[i]}};
    end
    return m;
  endfunction

  thp_pkg::thp_dev_state_t   state_ff, nxt_state;        // Access sequence
  logic [CW-1:0]             cnt_ff, nxt_cnt;            // Stretch counter
  logic                      style_ff, nxt_style;        // Style of this access
  logic                      ack_oe_ff, nxt_ack_oe;      // Acknowledge enable
  logic                      bus_error_n_oe_ff, nxt_bus_error_n_oe;    // Bus error enable
  logic                      wait_oe_ff, nxt_wait_oe;    // Wait enable
  logic                      doe_ff, nxt_doe;            // Data bus enable
  logic [`THP_DATA_W-1:0]    dout_ff, nxt_dout;          // Read data
  logic                      busy_ff, nxt_busy;          // Access in progress
  logic                      err_ff, nxt_err;            // Last access invalid
  logic [WW-1:0]             waddr_ff, nxt_waddr;        // Last word address
  logic [`THP_DATA_W-1:0]    mem [MEM_WORDS];            // Memory behind the port
  logic                      rel;                        // Reset released, synced
  logic                      sel;                        // Access requested
  logic [WW-1:0]             widx;                       // Word address
  logic                      valid;                      // Address in memory
  logic [`THP_DATA_W-1:0]    mask;                       // Lanes transferred
  logic                      mem_we;                     // Memory write this cycle
  logic [IW-1:0]             midx;                       // Memory index

  // Release of the device reset is aligned to the clock
  thp_rst_sync thp_rst_sync_inst (
    .clk_sys     (clk_sys),
    .async_rst_n (bus.device_reset_n),
    .rst_rel     (rel)
  );

  // Decode of the access on the pins
  always_comb begin
    sel   = !bus.cs_n && !bus.data_strobe_n;
    widx  = bus.host_address_bus[`THP_ADDR_W-1:1];
    valid = widx < WW'(MEM_WORDS);
    midx  = widx[IW-1:0];
    mask  = lane_mask(bus.byte_lane_select);
  end

  // Next values of the access sequence
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_style   = style_ff;
    nxt_ack_oe  = ack_oe_ff;
    nxt_bus_error_n_oe = bus_error_n_oe_ff;
    nxt_wait_oe = wait_oe_ff;
    nxt_doe     = doe_ff;
    nxt_dout    = dout_ff;
    nxt_busy    = busy_ff;
    nxt_err     = err_ff;
    nxt_waddr   = waddr_ff;
    mem_we      = 1'h0;
    unique case (state_ff)
      thp_pkg::DEV_IDLE: begin
        // New access: latch style, start stretching
        if (sel) begin
          nxt_state   = thp_pkg::DEV_STRETCH;
          nxt_style   = bus.bus_style_select;
          nxt_cnt     = CW'(WAIT_CYCLES - 1);
          nxt_wait_oe = 1'h1;
          nxt_busy    = 1'h1;
          nxt_waddr   = widx;
        end
      end
      thp_pkg::DEV_STRETCH: begin
        if (!sel) begin
          // Host gave up early: release everything
          nxt_state   = thp_pkg::DEV_IDLE;
          nxt_wait_oe = 1'h0;
          nxt_busy    = 1'h0;
        end else if (cnt_ff != '0) begin
          // Still stretching
          nxt_cnt = cnt_ff - CW'(1);
        end else begin
          // Complete the access
          nxt_state   = thp_pkg::DEV_ANSWER;
          nxt_wait_oe = 1'h0;
          nxt_bus_error_n_oe = !valid;
          nxt_err     = !valid;
          if (style_ff == `THP_STYLE_STROBE) begin
            nxt_ack_oe = valid;
          end else begin
            nxt_ack_oe = 1'h1;
          end
          if (bus.rd_wr == `THP_RW_READ) begin
            nxt_doe  = 1'h1;
            nxt_dout = valid ? (mem[midx] & mask) : '0;
          end else begin
            mem_we = valid;
          end
        end
      end
      thp_pkg::DEV_ANSWER: begin
        // Hold the answer until select or strobe rises
        if (!sel) begin
          nxt_state   = thp_pkg::DEV_IDLE;
          nxt_ack_oe  = 1'h0;
          nxt_bus_error_n_oe = 1'h0;
          nxt_doe     = 1'h0;
          nxt_busy    = 1'h0;
        end
      end
      default: begin
        // Illegal code recovers to idle
        nxt_state   = thp_pkg::DEV_IDLE;
        nxt_ack_oe  = 1'h0;
        nxt_bus_error_n_oe = 1'h0;
        nxt_wait_oe = 1'h0;
        nxt_doe     = 1'h0;
        nxt_busy    = 1'h0;
      end
    endcase
  end

  // Registers of the access sequence; device reset acts at once
  always_ff @(posedge clk_sys or negedge bus.device_reset_n) begin
    if (!bus.device_reset_n) begin
      state_ff   <= thp_pkg::DEV_IDLE;
      cnt_ff     <= '0;
      style_ff   <= `THP_STYLE_STROBE;
      ack_oe_ff  <= 1'h0;
      bus_error_n_oe_ff <= 1'h0;
      wait_oe_ff <= 1'h0;
      doe_ff     <= 1'h0;
      dout_ff    <= '0;
      busy_ff    <= 1'h0;
      err_ff     <= 1'h0;
      waddr_ff   <= '0;
    end else if (srst || !rel) begin
      state_ff   <= thp_pkg::DEV_IDLE;
      cnt_ff     <= '0;
      style_ff   <= `THP_STYLE_STROBE;
      ack_oe_ff  <= 1'h0;
      bus_error_n_oe_ff <= 1'h0;
      wait_oe_ff <= 1'h0;
      doe_ff     <= 1'h0;
      dout_ff    <= '0;
      busy_ff    <= 1'h0;
      err_ff     <= 1'h0;
      waddr_ff   <= '0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      style_ff   <= nxt_style;
      ack_oe_ff  <= nxt_ack_oe;
      bus_error_n_oe_ff <= nxt_bus_error_n_oe;
      wait_oe_ff <= nxt_wait_oe;
      doe_ff     <= nxt_doe;
      dout_ff    <= nxt_dout;
      busy_ff    <= nxt_busy;
      err_ff     <= nxt_err;
      waddr_ff   <= nxt_waddr;
    end
  end

  // Memory write, only the selected lanes change
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[midx] <= (mem[midx] & ~mask) | (bus.host_dout & mask);
    end
  end

  // Pin drive: levels are low whenever enabled
  assign bus.ack_o    = 1'h0;
  assign bus.bus_error_n_o   = 1'h0;
  assign bus.wait_o   = 1'h0;
  assign bus.ack_oe   = ack_oe_ff;
  assign bus.bus_error_n_oe  = bus_error_n_oe_ff;
  assign bus.wait_oe  = wait_oe_ff;
  assign bus.dev_doe  = doe_ff;
  assign bus.dev_dout = dout_ff;

  // Local status
  assign access_busy    = busy_ff;
  assign access_error   = err_ff;
  assign last_word_addr = waddr_ff;
endmodule // thp_dev_port

// file: verilog/thp_host_port.sv
// Host end of the host bus port: runs one access per user request.
// Assumes device answers arrive on the resolved lines of thp_bus_if.
`timescale 1ns/1ps
`include "thp_regs.svh"

module thp_host_port #(
  parameter int TIMEOUT = `THP_HOST_TIMEOUT
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  thp_bus_if.host                     bus,
  input  wire logic                   req,
  input  wire logic                   req_read,
  input  wire logic [`THP_ADDR_W-1:0] req_addr,
  input  wire logic [`THP_DATA_W-1:0] req_wdata,
  input  wire logic [`THP_LANES-1:0]  req_lanes_n,
  input  wire logic                   style_in,
  input  wire logic                   reset_in,
  output logic                        busy,
  output logic                        done,
  output logic [`THP_DATA_W-1:0]      rdata,
  output logic                        bus_err,
  output logic                        timed_out
);
  localparam int TW = $clog2(TIMEOUT + 1);

  thp_pkg::thp_hst_state_t   state_ff, nxt_state;   // Access sequence
  logic                      cs_n_ff, nxt_cs_n;     // Chip select
  logic                      ds_n_ff, nxt_ds_n;     // Data strobe
  logic                      rw_ff, nxt_rw;         // Direction
  logic [`THP_LANES-1:0]     lanes_ff, nxt_lanes;   // Lane inputs
  logic [`THP_ADDR_W-1:0]    addr_ff, nxt_addr;     // Address
  logic [`THP_DATA_W-1:0]    wdata_ff, nxt_wdata;   // Write data
  logic                      doe_ff, nxt_doe;       // Data bus enable
  logic                      style_ff, nxt_style;   // Bus style pin
  logic                      drst_n_ff, nxt_drst_n; // Device reset pin
  logic [TW-1:0]             tmo_ff, nxt_tmo;       // Timeout counter
  logic                      busy_ff, nxt_busy;
  logic                      done_ff, nxt_done;
  logic [`THP_DATA_W-1:0]    rdata_ff, nxt_rdata;
  logic                      bus_error_n_ff, nxt_bus_error_n;
  logic                      tmo_hit_ff, nxt_tmo_hit;
  logic                      finish;                // Answer seen

  // Next values of the access sequence
  always_comb begin
    nxt_state   = state_ff;
    nxt_cs_n    = cs_n_ff;
    nxt_ds_n    = ds_n_ff;
    nxt_rw      = rw_ff;
    nxt_lanes   = lanes_ff;
    nxt_addr    = addr_ff;
    nxt_wdata   = wdata_ff;
    nxt_doe     = doe_ff;
    nxt_style   = style_ff;
    nxt_drst_n  = !reset_in;
    nxt_tmo     = tmo_ff;
    nxt_busy    = busy_ff;
    nxt_done    = 1'h0;
    nxt_rdata   = rdata_ff;
    nxt_bus_error_n    = bus_error_n_ff;
    nxt_tmo_hit = tmo_hit_ff;
    // Style 0 ends on bus error alone; style 1 always waits for acknowledge
    finish = !bus.transfer_ack_n ||
             (!bus.bus_error_n && style_ff == `THP_STYLE_STROBE);
    unique case (state_ff)
      thp_pkg::HST_IDLE: begin
        nxt_style = style_in;
        if (req) begin
          // Present address, direction, lanes and write data
          nxt_state = thp_pkg::HST_SETUP;
          nxt_cs_n  = 1'h0;
          nxt_rw    = req_read ? `THP_RW_READ : `THP_RW_WRITE;
          nxt_lanes = req_lanes_n;
          nxt_addr  = {req_addr[`THP_ADDR_W-1:1], 1'h0};  // Bit 0 tied low
          nxt_wdata = req_wdata;
          nxt_doe   = !req_read;
          nxt_busy  = 1'h1;
        end
      end
      thp_pkg::HST_SETUP: begin
        // Strobe one cycle after select
        nxt_state = thp_pkg::HST_STROBE;
        nxt_ds_n  = 1'h0;
        nxt_tmo   = TW'(TIMEOUT);
      end
      thp_pkg::HST_STROBE: begin
        if (finish || tmo_ff == '0) begin
          // Take answer and end the cycle
          nxt_state   = thp_pkg::HST_RELEASE;
          nxt_cs_n    = 1'h1;
          nxt_ds_n    = 1'h1;
          nxt_doe     = 1'h0;
          nxt_rdata   = bus.host_data_bus;
          nxt_bus_error_n    = !bus.bus_error_n;
          nxt_tmo_hit = !finish;
        end else if (bus.wait_n) begin
          // Wait low holds the timeout
          nxt_tmo = tmo_ff - TW'(1);
        end
      end
      thp_pkg::HST_RELEASE: begin
        // Next access only after the device lets go
        if (bus.transfer_ack_n && bus.bus_error_n) begin
          nxt_state = thp_pkg::HST_IDLE;
          nxt_busy  = 1'h0;
          nxt_done  = 1'h1;
        end
      end
      default: nxt_state = thp_pkg::HST_IDLE;
    endcase
  end

  // Registers of the host end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff   <= thp_pkg::HST_IDLE;
      cs_n_ff    <= 1'h1;
      ds_n_ff    <= 1'h1;
      rw_ff      <= `THP_RW_READ;
      lanes_ff   <= '1;
      addr_ff    <= '0;
      wdata_ff   <= '0;
      doe_ff     <= 1'h0;
      style_ff   <= `THP_STYLE_STROBE;
      drst_n_ff  <= 1'h0;
      tmo_ff     <= '0;
      busy_ff    <= 1'h0;
      done_ff    <= 1'h0;
      rdata_ff   <= '0;
      bus_error_n_ff    <= 1'h0;
      tmo_hit_ff <= 1'h0;
    end else begin
      state_ff   <= nxt_state;
      cs_n_ff    <= nxt_cs_n;
      ds_n_ff    <= nxt_ds_n;
      rw_ff      <= nxt_rw;
      lanes_ff   <= nxt_lanes;
      addr_ff    <= nxt_addr;
      wdata_ff   <= nxt_wdata;
      doe_ff     <= nxt_doe;
      style_ff   <= nxt_style;
      drst_n_ff  <= nxt_drst_n;
      tmo_ff     <= nxt_tmo;
      busy_ff    <= nxt_busy;
      done_ff    <= nxt_done;
      rdata_ff   <= nxt_rdata;
      bus_error_n_ff    <= nxt_bus_error_n;
      tmo_hit_ff <= nxt_tmo_hit;
    end
  end

  // Pins and user outputs, all from registers
  assign bus.cs_n             = cs_n_ff;
  assign bus.data_strobe_n    = ds_n_ff;
  assign bus.rd_wr            = rw_ff;
  assign bus.byte_lane_select = lanes_ff;
  assign bus.host_address_bus = addr_ff;
  assign bus.host_dout        = wdata_ff;
  assign bus.host_doe         = doe_ff;
  assign bus.bus_style_select = style_ff;
  assign bus.device_reset_n   = drst_n_ff;
  assign busy                 = busy_ff;
  assign done                 = done_ff;
  assign rdata                = rdata_ff;
  assign bus_err              = bus_error_n_ff;
  assign timed_out            = tmo_hit_ff;
endmodule // thp_host_port

// file: verilog/thp_rst_sync.sv
// Reset release synchroniser for the device reset pin.
// Assumes the pin may fall at any time; release is aligned to clk_sys.
`timescale 1ns/1ps

module thp_rst_sync (
  input  wire logic clk_sys,
  input  wire logic async_rst_n,
  output logic      rst_rel
);
  logic meta_ff;  // First stage, read only by the second
  logic hold_ff;  // Second stage, released level

  // Assert at once, release two edges later
  always_ff @(posedge clk_sys or negedge async_rst_n) begin
    if (!async_rst_n) begin
      meta_ff <= 1'h0;
      hold_ff <= 1'h0;
    end else begin
      meta_ff <= 1'h1;
      hold_ff <= meta_ff;
    end
  end

  assign rst_rel = hold_ff;
endmodule // thp_rst_sync
